/* File: design/icr_top.sv */
`timescale 1ns/1ps
module icr_top #(
	parameter int NUM_PORTS       = 2,
	parameter int WD_TIMEOUT_LONG = icr_pkg::WD_LONG_CYC
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       nrst,

	// Register access port
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic                       reg_from_remote,
	input  wire logic                       second_port_select,
	output logic [7:0]                      reg_rdata,
	output logic                            reg_ack,
	output logic                            reg_reject,

	// Receiver lock and learned deserializer address per port
	input  wire logic [NUM_PORTS-1:0]       rx_lock,
	input  wire logic [NUM_PORTS-1:0][6:0]  lock_deser_addr,

	// Transaction address from the local master
	input  wire logic                       txn_valid,
	input  wire logic [6:0]                 txn_addr,
	output logic                            fwd_valid,
	output icr_pkg::icr_fwd_type            fwd,
	output logic                            fwd_port,

	// Local bus lines, open drain
	input  wire logic                       scl_in,
	input  wire logic                       sda_in,
	input  wire logic                       sda_drive_low,
	output logic                            scl_out,
	output logic                            scl_oe,
	output logic                            sda_out,
	output logic                            sda_oe,

	// Watchdog status
	output logic                            bus_free,
	output logic                            bus_recovering
);

	//--------------------------------------------------------------------------
	// Register state
	//--------------------------------------------------------------------------

	icr_pkg::icr_ctrl_type ctrl_reg;
	icr_pkg::icr_id_type   deser_reg  [NUM_PORTS];
	icr_pkg::icr_id_type   target_reg [NUM_PORTS];
	icr_pkg::icr_id_type   alias_reg  [NUM_PORTS];
	icr_pkg::icr_id_type   deser_next [NUM_PORTS];
	logic [NUM_PORTS-1:0]  lock_prev_reg;
	logic [NUM_PORTS-1:0]  lock_rise;

	logic [7:0]            reg_rdata_reg;
	logic                  reg_ack_reg;
	logic                  reg_reject_reg;

	//--------------------------------------------------------------------------
	// Register decode
	//--------------------------------------------------------------------------

	logic                  port_sel;
	logic                  hit_ctrl;
	logic                  hit_deser;
	logic                  hit_target;
	logic                  hit_alias;
	logic                  wr_blocked;
	logic                  wr_ok;
	logic [7:0]            rd_value;

	// Port view select for the per-port address registers.
	assign port_sel   = second_port_select && (NUM_PORTS > 1);

	// Offset decode.
	assign hit_ctrl   = (reg_addr == icr_pkg::OFF_I2C_CONTROL);
	assign hit_deser  = (reg_addr == icr_pkg::OFF_REMOTE_DESER);
	assign hit_target = (reg_addr == icr_pkg::OFF_TARGET_ADDR);
	assign hit_alias  = (reg_addr == icr_pkg::OFF_TARGET_ALIAS);

	// Writes arriving over the control channel are refused while blocked.
	// Only this register port is gated; forwarding of remote traffic to targets
	// on the local bus does not pass through here and is never held back.
	assign wr_blocked = reg_wr && reg_from_remote && ctrl_reg.local_wr_block;
	assign wr_ok      = reg_wr && !wr_blocked;

	// Read mux; reserved bits and unmapped offsets read as zero.
	assign rd_value =
		hit_ctrl   ? (ctrl_reg & icr_pkg::MASK_I2C_CONTROL) :
		hit_deser  ? deser_reg[port_sel] :
		hit_target ? (target_reg[port_sel] & icr_pkg::MASK_TARGET) :
		hit_alias  ? (alias_reg[port_sel] & icr_pkg::MASK_TARGET) :
		8'h00;

	//--------------------------------------------------------------------------
	// Deserializer address loading
	//--------------------------------------------------------------------------

	// A rising lock edge marks a fresh link on that port.
	assign lock_rise = rx_lock & ~lock_prev_reg;

	// Software write first, then the learned address unless the hold bit is
	// set, including a hold bit written in this same cycle.
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			deser_next[p] = deser_reg[p];
			if (wr_ok && hit_deser && (port_sel == p[0])) begin
				deser_next[p] = reg_wdata;
			end
			if (lock_rise[p] && !deser_next[p].flag) begin
				deser_next[p].addr = lock_deser_addr[p];
			end
		end
	end

	// Control register; reserved bits are never stored.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= icr_pkg::RST_I2C_CONTROL;
		end else if (wr_ok && hit_ctrl) begin
			ctrl_reg <= reg_wdata & icr_pkg::MASK_I2C_CONTROL;
		end
	end

	// Per-port address registers.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				deser_reg[p]  <= icr_pkg::RST_ID;
				target_reg[p] <= icr_pkg::RST_ID;
				alias_reg[p]  <= icr_pkg::RST_ID;
			end
			lock_prev_reg <= '0;
		end else begin
			lock_prev_reg <= rx_lock;
			for (int p = 0; p < NUM_PORTS; p++) begin
				deser_reg[p] <= deser_next[p];
				if (wr_ok && hit_target && (port_sel == p[0])) begin
					target_reg[p] <= reg_wdata & icr_pkg::MASK_TARGET;
				end
				if (wr_ok && hit_alias && (port_sel == p[0])) begin
					alias_reg[p] <= reg_wdata & icr_pkg::MASK_TARGET;
				end
			end
		end
	end

	// Registered read data and one-cycle answer strobes.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_reg  <= 8'h00;
			reg_ack_reg    <= 1'b0;
			reg_reject_reg <= 1'b0;
		end else begin
			reg_rdata_reg  <= reg_rd ? rd_value : reg_rdata_reg;
			reg_ack_reg    <= reg_rd || wr_ok;
			reg_reject_reg <= wr_blocked;
		end
	end

	assign reg_rdata  = reg_rdata_reg;
	assign reg_ack    = reg_ack_reg;
	assign reg_reject = reg_reject_reg;

	//--------------------------------------------------------------------------
	// Alias remapping
	//--------------------------------------------------------------------------

	logic [NUM_PORTS-1:0]      port_hit;
	logic [NUM_PORTS-1:0]      port_to_target;
	logic [NUM_PORTS-1:0][6:0] port_addr;
	logic                      any_hit;
	logic                      win_port;
	icr_pkg::icr_fwd_type      fwd_reg;
	logic                      fwd_valid_reg;
	logic                      fwd_port_reg;

	// One matcher per port; each compares against its own fields.
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_remap
		icr_remap u_remap (
			.txn_addr  (txn_addr),
			.deser     (deser_reg[g]),
			.target    (target_reg[g]),
			.alias_id  (alias_reg[g]),
			.hit       (port_hit[g]),
			.to_target (port_to_target[g]),
			.fwd_addr  (port_addr[g])
		);
	end

	// The first port wins when both match the same address.
	assign any_hit  = |port_hit;
	assign win_port = !port_hit[0] && (NUM_PORTS > 1);

	// Forwarded address with the target substituted for an alias match.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fwd_reg       <= '0;
			fwd_valid_reg <= 1'b0;
			fwd_port_reg  <= 1'b0;
		end else begin
			fwd_valid_reg <= txn_valid;
			if (txn_valid) begin
				fwd_reg.remote    <= any_hit;
				fwd_reg.to_target <= any_hit && port_to_target[win_port];
				fwd_reg.addr      <= any_hit ? port_addr[win_port] : txn_addr;
				fwd_port_reg      <= win_port;
			end
		end
	end

	assign fwd       = fwd_reg;
	assign fwd_valid = fwd_valid_reg;
	assign fwd_port  = fwd_port_reg;

	//--------------------------------------------------------------------------
	// SDA output delay
	//--------------------------------------------------------------------------

	logic       scl_prev_reg;
	logic       scl_fall;
	logic [3:0] dly_cycles;
	logic [3:0] dly_cnt_reg;
	logic       sda_oe_reg;

	// Delay is a base time plus one step per field count.
	assign scl_fall   = scl_prev_reg && !scl_in;
	assign dly_cycles = 4'(icr_pkg::SDA_BASE_CYC)
		+ 4'(ctrl_reg.sda_delay) * 4'(icr_pkg::SDA_STEP_CYC);

	// SDA drive changes only after the delay from a falling SCL edge, so the
	// data never moves while SCL is near its high level.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_prev_reg <= 1'b1;
			dly_cnt_reg  <= 4'h0;
			sda_oe_reg   <= 1'b0;
		end else begin
			scl_prev_reg <= scl_in;
			if (scl_fall) begin
				dly_cnt_reg <= dly_cycles;
			end else if (dly_cnt_reg == 4'h1) begin
				dly_cnt_reg <= 4'h0;
				sda_oe_reg  <= sda_drive_low;
			end else if (dly_cnt_reg != 4'h0) begin
				dly_cnt_reg <= dly_cnt_reg - 4'h1;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Bus watchdog
	//--------------------------------------------------------------------------

	logic wd_scl_oe;
	logic scl_out_reg;
	logic sda_out_reg;

	// Idle timer with free detection and clock-out recovery.
	icr_watchdog #(
		.TIMEOUT_LONG  (WD_TIMEOUT_LONG),
		.TIMEOUT_SHORT (icr_pkg::WD_SHORT_CYC),
		.HALF_CYC      (icr_pkg::RECOVER_HALF_CYC)
	) u_watchdog (
		.clk        (clk),
		.nrst       (nrst),
		.wd_disable (ctrl_reg.wd_disable),
		.wd_speedup (ctrl_reg.wd_speedup),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.bus_free   (bus_free),
		.recovering (bus_recovering),
		.scl_oe     (wd_scl_oe)
	);

	// Open-drain lines only ever pull low.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_out_reg <= 1'b0;
			sda_out_reg <= 1'b0;
		end else begin
			scl_out_reg <= 1'b0;
			sda_out_reg <= 1'b0;
		end
	end

	assign scl_out = scl_out_reg;
	assign sda_out = sda_out_reg;
	assign scl_oe  = wd_scl_oe;
	assign sda_oe  = sda_oe_reg;

endmodule

/* File: design/icr_pkg.sv */
//------------------------------------------------------------------------------
// Control channel remap package
//------------------------------------------------------------------------------
package icr_pkg;

	// Clock rate.
	localparam int CLK_PERIOD_NS = 40;

	// Register offsets.
	localparam logic [7:0] OFF_I2C_CONTROL  = 8'h05;
	localparam logic [7:0] OFF_REMOTE_DESER = 8'h06;
	localparam logic [7:0] OFF_TARGET_ADDR  = 8'h07;
	localparam logic [7:0] OFF_TARGET_ALIAS = 8'h08;

	// Values after reset.
	localparam logic [7:0] RST_I2C_CONTROL = 8'h00;
	localparam logic [7:0] RST_ID          = 8'h00;

	// Reserved bit masks.
	localparam logic [7:0] MASK_I2C_CONTROL = 8'h1f;
	localparam logic [7:0] MASK_TARGET      = 8'hfe;

	// Times in their own units.
	localparam int SDA_BASE_NS     = 240;
	localparam int SDA_STEP_NS     = 40;
	localparam int WD_LONG_NS      = 1_000_000_000;
	localparam int WD_SHORT_NS     = 50_000;
	localparam int RECOVER_HALF_NS = 5_000;
	localparam int RECOVER_PULSES  = 9;

	// Least time in whole cycles, never below one.
	function automatic int ceil_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Longest time in whole cycles, never below one.
	function automatic int floor_cycles(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Cycle counts.
	localparam int SDA_BASE_CYC     = ceil_cycles(SDA_BASE_NS);
	localparam int SDA_STEP_CYC     = ceil_cycles(SDA_STEP_NS);
	localparam int WD_LONG_CYC      = floor_cycles(WD_LONG_NS);
	localparam int WD_SHORT_CYC     = floor_cycles(WD_SHORT_NS);
	localparam int RECOVER_HALF_CYC = floor_cycles(RECOVER_HALF_NS);

	// Control register layout.
	typedef struct packed {
		logic [2:0] rsvd;
		logic [1:0] sda_delay;
		logic       local_wr_block;
		logic       wd_speedup;
		logic       wd_disable;
	} icr_ctrl_type;

	// Address register layout: address in 7:1, flag or reserved in 0.
	typedef struct packed {
		logic [6:0] addr;
		logic       flag;
	} icr_id_type;

	// Forwarded transaction address.
	typedef struct packed {
		logic       remote;
		logic       to_target;
		logic [6:0] addr;
	} icr_fwd_type;

	// Watchdog states.
	typedef enum logic [1:0] {
		WD_WATCH,
		WD_FREE,
		WD_RECOVER
	} icr_wd_state_type;

endpackage

/* File: design/icr_remap.sv */
`timescale 1ns/1ps
module icr_remap (
	// Transaction address from the local master
	input  wire logic [6:0]         txn_addr,
	// Address fields of one port
	input  wire icr_pkg::icr_id_type deser,
	input  wire icr_pkg::icr_id_type target,
	input  wire icr_pkg::icr_id_type alias_id,
	// Match result
	output logic                     hit,
	output logic                     to_target,
	output logic [6:0]               fwd_addr
);

	// A zero address field means the entry is switched off.
	function automatic logic addr_enabled(input logic [6:0] a);
		return a != 7'h00;
	endfunction

	logic deser_hit;
	logic alias_hit;

	// Deserializer match wins over an alias match.
	assign deser_hit = addr_enabled(deser.addr) && (txn_addr == deser.addr);
	assign alias_hit = addr_enabled(target.addr) && addr_enabled(alias_id.addr)
		&& (txn_addr == alias_id.addr);
	assign hit       = deser_hit | alias_hit;
	assign to_target = alias_hit & ~deser_hit;
	assign fwd_addr  = to_target ? target.addr : txn_addr;

endmodule

/* File: design/icr_watchdog.sv */
`timescale 1ns/1ps
module icr_watchdog #(
	parameter int TIMEOUT_LONG  = icr_pkg::WD_LONG_CYC,
	parameter int TIMEOUT_SHORT = icr_pkg::WD_SHORT_CYC,
	parameter int HALF_CYC      = icr_pkg::RECOVER_HALF_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Configuration
	input  wire logic wd_disable,
	input  wire logic wd_speedup,
	// Bus lines
	input  wire logic scl_in,
	input  wire logic sda_in,
	// Status and recovery drive
	output logic      bus_free,
	output logic      recovering,
	output logic      scl_oe
);

	localparam int CW = $clog2(TIMEOUT_LONG + TIMEOUT_SHORT + 1);
	localparam int HW = $clog2(HALF_CYC + 1);

	icr_pkg::icr_wd_state_type state_reg;
	logic [CW-1:0]             cnt_reg;
	logic [HW-1:0]             half_reg;
	logic [3:0]                pulse_reg;
	logic                      scl_prev_reg;
	logic                      sda_prev_reg;
	logic                      scl_oe_reg;
	logic [CW-1:0]             limit;
	logic                      activity;
	logic                      expired;
	logic                      half_end;

	// Interval select and activity detection.
	assign limit    = wd_speedup ? CW'(TIMEOUT_SHORT) : CW'(TIMEOUT_LONG);
	assign activity = (scl_in != scl_prev_reg) || (sda_in != sda_prev_reg);
	assign expired  = (cnt_reg >= limit - CW'(1));
	assign half_end = (half_reg == HW'(HALF_CYC - 1));

	// Idle timer, free detection and nine-pulse recovery.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg    <= icr_pkg::WD_WATCH;
			cnt_reg      <= '0;
			half_reg     <= '0;
			pulse_reg    <= 4'h0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			scl_oe_reg   <= 1'b0;
		end else begin
			scl_prev_reg <= scl_in;
			sda_prev_reg <= sda_in;
			case (state_reg)
				icr_pkg::WD_WATCH: begin
					if (wd_disable || activity) begin
						cnt_reg <= '0;
					end else if (expired) begin
						cnt_reg   <= '0;
						half_reg  <= '0;
						pulse_reg <= 4'h0;
						if (sda_in) begin
							state_reg <= icr_pkg::WD_FREE;
						end else begin
							state_reg  <= icr_pkg::WD_RECOVER;
							scl_oe_reg <= 1'b1;
						end
					end else begin
						cnt_reg <= cnt_reg + CW'(1);
					end
				end
				icr_pkg::WD_FREE: begin
					if (wd_disable || activity) begin
						state_reg <= icr_pkg::WD_WATCH;
					end
				end
				icr_pkg::WD_RECOVER: begin
					half_reg <= half_end ? '0 : half_reg + HW'(1);
					if (half_end && scl_oe_reg) begin
						scl_oe_reg <= 1'b0;
						pulse_reg  <= pulse_reg + 4'h1;
					end else if (half_end) begin
						if (pulse_reg == 4'(icr_pkg::RECOVER_PULSES)) begin
							state_reg <= icr_pkg::WD_WATCH;
						end else begin
							scl_oe_reg <= 1'b1;
						end
					end
				end
				default: begin
					state_reg  <= icr_pkg::WD_WATCH;
					scl_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	assign bus_free   = (state_reg == icr_pkg::WD_FREE);
	assign recovering = (state_reg == icr_pkg::WD_RECOVER);
	assign scl_oe     = scl_oe_reg;

endmodule

/* File: verif/icr_monitor.sv */
`timescale 1ns/1ps
module icr_monitor #(
	parameter int NUM_PORTS       = 2,
	parameter int WD_TIMEOUT_LONG = 2000
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic       reg_from_remote,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_ack,
	input wire logic       reg_reject,
	// Forwarding and bus
	input wire logic       txn_valid,
	input wire logic       fwd_valid,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_drive_low,
	input wire logic       scl_oe,
	input wire logic       sda_oe,
	input wire logic       bus_free,
	input wire logic       bus_recovering
);
	//--------------------------------------------------------------
	// Shadow state
	//--------------------------------------------------------------
	logic [7:0]  ctrl_sh;
	logic [3:0]  dly_cnt;
	logic [15:0] idle_cnt;
	logic [3:0]  pulse_cnt;
	logic        scl_q;
	logic        sda_q;
	logic        scl_oe_q;
	logic [31:0] lim;
	logic        blocked;

	// Blocked writes and the active watchdog limit.
	assign blocked = reg_from_remote & ctrl_sh[2];
	assign lim = ctrl_sh[1] ? 32'd1250 : WD_TIMEOUT_LONG;

	// Tracks control, the SDA delay count, bus idle time and recovery pulses.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_sh <= 8'h00;
			dly_cnt <= 4'h0;
			idle_cnt <= 16'h0000;
			pulse_cnt <= 4'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_oe_q <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == 8'h05 && !blocked)
				ctrl_sh <= reg_wdata & 8'h1f;
			if (scl_q && !scl_in)
				dly_cnt <= 4'h6 + {2'h0, ctrl_sh[4:3]};
			else if (dly_cnt != 4'h0)
				dly_cnt <= dly_cnt - 4'h1;
			if (scl_in != scl_q || sda_in != sda_q)
				idle_cnt <= 16'h0000;
			else if (idle_cnt != 16'hffff)
				idle_cnt <= idle_cnt + 16'h0001;
			pulse_cnt <= bus_recovering ? pulse_cnt + {3'h0, scl_oe & !scl_oe_q} : 4'h0;
			scl_q <= scl_in;
			sda_q <= sda_in;
			scl_oe_q <= scl_oe;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	blk_reject_a: assert property (reg_wr && blocked |=> reg_reject && !reg_ack)
		else $error("blocked remote write not refused");
	wr_accept_a: assert property (reg_wr && !blocked |=> reg_ack && !reg_reject)
		else $error("write not acknowledged");
	ctrl_read_a: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata == ctrl_sh)
		else $error("control readback wrong");
	rsvd_zero_a: assert property (reg_rd && reg_addr[7:1] == 7'h04 |=> !reg_rdata[0])
		else $error("reserved address bit reads one");
	fwd_timing_a: assert property (fwd_valid == $past(txn_valid))
		else $error("forward strobe not one cycle after request");
	sda_take_a: assert property (dly_cnt == 4'h1 |=> sda_oe == $past(sda_drive_low))
		else $error("sda drive not taken at delay end");
	sda_hold_a: assert property (dly_cnt != 4'h1 |=> $stable(sda_oe))
		else $error("sda drive changed outside delay end");
	wd_free_a: assert property (idle_cnt == lim + 10 && !ctrl_sh[0] && sda_in |-> bus_free)
		else $error("idle bus not judged free");
	wd_early_a: assert property ($rose(bus_free) |-> sda_in && idle_cnt >= lim - 10)
		else $error("bus judged free too early");
	wd_off_a: assert property (ctrl_sh[0] && $past(ctrl_sh[0]) |-> !$rose(bus_free) && !$rose(bus_recovering))
		else $error("watchdog acted while disabled");
	rec_start_a: assert property ($rose(bus_recovering) |-> !sda_in && idle_cnt >= lim - 10)
		else $error("recovery started wrongly");
	rec_count_a: assert property ($fell(bus_recovering) |-> pulse_cnt == 4'h9)
		else $error("recovery pulse count wrong");
	rec_only_a: assert property (scl_oe |-> bus_recovering)
		else $error("scl driven outside recovery");
endmodule

bind icr_top icr_monitor #(.NUM_PORTS(NUM_PORTS), .WD_TIMEOUT_LONG(WD_TIMEOUT_LONG)) icr_monitor_inst (
	.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_from_remote(reg_from_remote), .reg_rdata(reg_rdata),
	.reg_ack(reg_ack), .reg_reject(reg_reject), .txn_valid(txn_valid), .fwd_valid(fwd_valid),
	.scl_in(scl_in), .sda_in(sda_in), .sda_drive_low(sda_drive_low), .scl_oe(scl_oe),
	.sda_oe(sda_oe), .bus_free(bus_free), .bus_recovering(bus_recovering));

/* File: verif/icr_bus_model.sv */
`timescale 1ns/1ps
module icr_bus_model (
	// Pull-down requests of each party
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic scl_hold_low,
	input  wire logic sda_hold_low,
	// Wire levels
	output logic      scl_in,
	output logic      sda_in
);
	// Pull-ups lift each wire unless some party pulls it low.
	assign scl_in = !(scl_oe || scl_hold_low);
	assign sda_in = !(sda_oe || sda_hold_low);
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
	//--------------------------------------------------------------
	// Signals
	//--------------------------------------------------------------
	logic clk, nrst, reg_wr, reg_rd, reg_from_remote, second_port_select;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_ack, reg_reject, txn_valid, fwd_valid, fwd_port;
	logic [1:0] rx_lock;
	logic [1:0][6:0] lock_deser_addr;
	logic [6:0] txn_addr;
	icr_pkg::icr_fwd_type fwd;
	logic scl_in, sda_in, sda_drive_low, scl_out, scl_oe, sda_out, sda_oe;
	logic bus_free, bus_recovering, scl_hold_low, sda_hold_low;
	int n_fail, tests_run, cyc;

	icr_top #(.NUM_PORTS(2), .WD_TIMEOUT_LONG(2000)) icr_top_inst (
		.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_from_remote(reg_from_remote),
		.second_port_select(second_port_select), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.reg_reject(reg_reject), .rx_lock(rx_lock), .lock_deser_addr(lock_deser_addr),
		.txn_valid(txn_valid), .txn_addr(txn_addr), .fwd_valid(fwd_valid), .fwd(fwd),
		.fwd_port(fwd_port), .scl_in(scl_in), .sda_in(sda_in), .sda_drive_low(sda_drive_low),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
		.bus_free(bus_free), .bus_recovering(bus_recovering));

	icr_bus_model icr_bus_model_inst (.scl_oe(scl_oe), .sda_oe(sda_oe),
		.scl_hold_low(scl_hold_low), .sda_hold_low(sda_hold_low), .scl_in(scl_in), .sda_in(sda_in));

	// Clock and hang guard.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			$display("unexpected hang: run passed its cycle ceiling");
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem, input logic blk);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_from_remote <= rem;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
		check("ack", {8'h00, reg_ack}, {8'h00, !blk});
		check("reject", {8'h00, reg_reject}, {8'h00, blk});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("rdata", {1'b0, reg_rdata}, {1'b0, e});
	endtask

	task automatic txn(input logic [6:0] a, input logic [8:0] e, input logic p);
		@(posedge clk);
		txn_addr <= a;
		txn_valid <= 1'b1;
		@(posedge clk);
		txn_valid <= 1'b0;
		#1;
		check("fwd", fwd, e);
		check("port", {8'h00, fwd_port}, {8'h00, p});
	endtask

	// Waits for a flag, returning the cycles spent.
	task automatic wait_flag(ref logic f, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (f !== 1'b1 && n < lim);
	endtask

	task automatic pulse_scl();
		@(posedge clk);
		scl_hold_low <= 1'b1;
		@(posedge clk);
		scl_hold_low <= 1'b0;
	endtask

	//--------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------
	task automatic t_regs();
		for (int a = 5; a < 9; a++) rd(a[7:0], 8'h00);
		wr(8'h05, 8'hff, 1'b0, 1'b0);
		rd(8'h05, 8'h1f);
		wr(8'h07, 8'hff, 1'b0, 1'b0);
		rd(8'h07, 8'hfe);
		wr(8'h08, 8'hff, 1'b0, 1'b0);
		rd(8'h08, 8'hfe);
		wr(8'h06, 8'hff, 1'b0, 1'b0);
		rd(8'h06, 8'hff);
		wr(8'h20, 8'h55, 1'b0, 1'b0);
		rd(8'h20, 8'h00);
		for (int a = 5; a < 9; a++) wr(a[7:0], 8'h00, 1'b0, 1'b0);
		$display("done registers");
	endtask

	task automatic t_block();
		wr(8'h05, 8'h04, 1'b0, 1'b0);
		wr(8'h07, 8'h5a, 1'b1, 1'b1);
		rd(8'h07, 8'h00);
		wr(8'h05, 8'h00, 1'b1, 1'b1);
		txn(7'h10, {2'b00, 7'h10}, 1'b1);
		wr(8'h05, 8'h00, 1'b0, 1'b0);
		wr(8'h07, 8'h5a, 1'b1, 1'b0);
		rd(8'h07, 8'h5a);
		$display("done write block");
	endtask

	task automatic t_remap();
		wr(8'h07, 8'ha0, 1'b0, 1'b0);
		wr(8'h08, 8'h42, 1'b0, 1'b0);
		txn(7'h21, {2'b11, 7'h50}, 1'b0);
		txn(7'h33, {2'b00, 7'h33}, 1'b1);
		wr(8'h06, 8'h74, 1'b0, 1'b0);
		txn(7'h3a, {2'b10, 7'h3a}, 1'b0);
		wr(8'h06, 8'h00, 1'b0, 1'b0);
		txn(7'h00, {2'b00, 7'h00}, 1'b1);
		wr(8'h08, 8'h00, 1'b0, 1'b0);
		txn(7'h21, {2'b00, 7'h21}, 1'b1);
		wr(8'h08, 8'h42, 1'b0, 1'b0);
		wr(8'h07, 8'h00, 1'b0, 1'b0);
		txn(7'h21, {2'b00, 7'h21}, 1'b1);
		@(posedge clk);
		second_port_select <= 1'b1;
		wr(8'h07, 8'ha2, 1'b0, 1'b0);
		wr(8'h08, 8'h44, 1'b0, 1'b0);
		rd(8'h08, 8'h44);
		@(posedge clk);
		second_port_select <= 1'b0;
		rd(8'h08, 8'h42);
		txn(7'h22, {2'b11, 7'h51}, 1'b1);
		$display("done remap");
	endtask

	task automatic relock();
		@(posedge clk);
		rx_lock[0] <= 1'b0;
		@(posedge clk);
		rx_lock[0] <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	task automatic t_lock();
		@(posedge clk);
		lock_deser_addr[0] <= 7'h12;
		relock();
		rd(8'h06, 8'h24);
		wr(8'h06, 8'h67, 1'b0, 1'b0);
		relock();
		rd(8'h06, 8'h67);
		wr(8'h06, 8'h66, 1'b0, 1'b0);
		relock();
		rd(8'h06, 8'h24);
		$display("done address load");
	endtask

	task automatic t_sda();
		logic drv;
		int n;
		for (int f = 0; f < 4; f++) begin
			drv = !f[0];
			wr(8'h05, {3'h0, f[1:0], 3'h0}, 1'b0, 1'b0);
			@(posedge clk);
			sda_drive_low <= drv;
			repeat (3) @(posedge clk);
			scl_hold_low <= 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (sda_oe !== drv && n < 20);
			check("sda delay", 9'(n - 1), 9'(6 + f));
			@(posedge clk);
			scl_hold_low <= 1'b0;
		end
		$display("done sda delay");
	endtask

	task automatic t_wd();
		int n;
		int p;
		logic prev;
		wr(8'h05, 8'h02, 1'b0, 1'b0);
		pulse_scl();
		wait_flag(bus_free, 1400, n);
		check("short free", 9'(n >= 1240 && n <= 1260), 9'h001);
		pulse_scl();
		#1;
		check("free cleared", {8'h00, bus_free}, 9'h000);
		@(posedge clk);
		sda_hold_low <= 1'b1;
		wait_flag(bus_recovering, 1400, n);
		check("recover start", 9'(n >= 1240 && n <= 1260), 9'h001);
		p = 0;
		n = 0;
		prev = 1'b0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (scl_oe === 1'b1 && !prev) p++;
			prev = scl_oe;
		end while (bus_recovering === 1'b1 && n < 3000);
		check("pulses", 9'(p), 9'h009);
		@(posedge clk);
		sda_hold_low <= 1'b0;
		wr(8'h05, 8'h00, 1'b0, 1'b0);
		pulse_scl();
		wait_flag(bus_free, 2200, n);
		check("long free", 9'(n >= 1990 && n <= 2010), 9'h001);
		wr(8'h05, 8'h01, 1'b0, 1'b0);
		pulse_scl();
		sda_hold_low <= 1'b1;
		repeat (2200) @(posedge clk);
		#1;
		check("off free", {8'h00, bus_free}, 9'h000);
		check("off recover", {8'h00, bus_recovering}, 9'h000);
		check("line data", {7'h00, scl_out, sda_out}, 9'h000);
		$display("done watchdog");
	endtask

	// Main sequence.
	initial begin
		{nrst, reg_wr, reg_rd, reg_from_remote, second_port_select, txn_valid} = 6'h00;
		{sda_drive_low, scl_hold_low, sda_hold_low} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		rx_lock = 2'h0;
		lock_deser_addr = 14'h0000;
		txn_addr = 7'h00;
		n_fail = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_block();
		t_remap();
		t_lock();
		t_sda();
		t_wd();
		tally_and_finish();
	end
endmodule
